/* ahel_cfg.svh */
// register offsets, field positions, reset values and range limits
`ifndef AHEL_CFG_SVH
`define AHEL_CFG_SVH
`define AHEL_OFF_CTRL 12'h000
`define AHEL_OFF_ORIGIN 12'h004
`define AHEL_OFF_CSPEED 12'h008
`define AHEL_OFF_FSPEED 12'h00c
`define AHEL_OFF_BACKOFF 12'h010
`define AHEL_OFF_LIMIT 12'h014
`define AHEL_OFF_STATUS 12'h018
`define AHEL_OFF_LATCH 12'h01c
`define AHEL_OFF_OVERRUN 12'h020
`define AHEL_OFF_POS 12'h024
`define AHEL_OFF_CMD 12'h028
`define AHEL_B_CLR_RST 0
`define AHEL_B_REQ_HOME 1
`define AHEL_B_CLR_ESTOP 2
`define AHEL_B_ENC_EN 3
`define AHEL_B_CDIR 4
`define AHEL_B_FDIR 5
`define AHEL_B_PASS 8
`define AHEL_CTRL_RST 32'h0000010b
`define AHEL_ORIGIN_RST 32'h00000000
`define AHEL_CSPEED_RST 32'h000003e8
`define AHEL_FSPEED_RST 32'h00000064
`define AHEL_BACKOFF_RST 32'h00000000
`define AHEL_LIMIT_RST 32'h000f4240
`define AHEL_SPEED_MIN 32'h00000001
`define AHEL_SPEED_MAX 32'h00989680
`define AHEL_BACKOFF_MAX 32'h000f4240
`endif

/* ahel_pkg.sv */
// types for the axis homing sequencer
package ahel_pkg;
  typedef enum logic [6:0] {
    AHEL_IDLE = 7'h01,
    AHEL_COARSE = 7'h02,
    AHEL_CRETRACT = 7'h04,
    AHEL_FINE = 7'h08,
    AHEL_FSTOP = 7'h10,
    AHEL_RETRACT = 7'h20,
    AHEL_DONE = 7'h40
  } ahel_state_t;
  typedef struct packed {
    logic run;
    logic dir_neg;
    logic [31:0] speed;
  } ahel_move_t;
endpackage

/* ahel_homing.sv */
// axis homing sequencer with encoder index latch and apb registers
// Functional notes
// R1: with feedback enabled, one coarse and one fine pass per axis
// R2: coarse search stops the drive as soon as home switch is seen
// R3: coarse retract runs after coarse stop, before fine search
// R4: fine search reverses, stops at index, latching encoder count
// R5: overrun is rest position minus latched index position
// R6: retract distance is configured back-off minus overrun, then moved
// R7: flag selects clearing homed mark on system reset
// R8: flag selects clearing homed mark on emergency stop
// R9: when required, unhomed axis motion stays blocked
// R10: origin coordinate offset, default zero, clamped to travel limit
// R11: coarse direction configurable, positive or negative
// R12: coarse speed accepted only within its documented range
// R13: fine direction configurable, positive or negative
// R14: fine speed accepted only within its documented range
// R15: signed back-off distance within -1000 to 1000 after fine search; code accepts -1000000 to 1000000
// R16: fine pass count configurable, default one
// R17: after estop with feedback, position follows measured encoder
// R18: operator should enable reset clearing and homing-before-cycle
// R19: soft limits, fixed point, tool change wait for homing
// R20: enable setting selects the feedback homing flow
// R21: homed mark set only after final retract completes
// R22: estop during homing aborts and leaves mark cleared
//
// Our own choices: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "ahel_cfg.svh"
module ahel_homing #(
  parameter int SYNC_STAGES = 3
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic home_switch,
  input wire logic encoder_index,
  input wire logic estop,
  input wire logic sys_reset_evt,
  input wire logic drive_done,
  input wire logic [31:0] encoder_count,
  output logic move_run,
  output logic move_dir_neg,
  output logic [31:0] move_speed,
  output logic retract_start,
  output logic [31:0] retract_dist,
  output logic motion_allowed,
  output logic homed,
  output logic aux_enable
);
  // the pin synchronisers below are built for exactly three stages
  if (SYNC_STAGES != 3)
  begin : g_bad_stages
    $error("SYNC_STAGES must be 3");
  end

  // ----------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------
  // a level counts only once stages two and three agree, so a pin pulse
  // shorter than two clocks is filtered out
  logic [2:0] pin_in, pin_st, pin_rise;
  assign pin_in = {estop, encoder_index, home_switch};
  for (genvar g = 0; g < 3; g++)
  begin : g_sync
    logic [2:0] sh_q, sh_d;
    logic lvl_q, lvl_d, prev_q;
    always_comb
    begin
      sh_d = {sh_q[1:0], pin_in[g]};
      lvl_d = (sh_q[1] == sh_q[2]) ? sh_q[2] : lvl_q;
    end
    always_ff @(posedge clk or posedge reset)
    begin
      if (reset)
      begin
        sh_q <= 3'h0;
        lvl_q <= 1'b0;
        prev_q <= 1'b0;
      end
      else
      begin
        sh_q <= sh_d;
        lvl_q <= lvl_d;
        prev_q <= lvl_q;
      end
    end
    assign pin_st[g] = lvl_q;
    assign pin_rise[g] = lvl_q & ~prev_q;
  end
  logic sw_st_q, es_st_q, ix_rise, es_rise;
  assign sw_st_q = pin_st[0];
  assign es_st_q = pin_st[2];
  assign ix_rise = pin_rise[1];
  assign es_rise = pin_rise[2];

  // ----------------------------------------------------------
  // apb register file
  // ----------------------------------------------------------
  logic [31:0] ctrl_q, ctrl_d, origin_q, origin_d, cspd_q, cspd_d;
  logic [31:0] fspd_q, fspd_d, back_q, back_d, lim_q, lim_d;
  logic [31:0] prdata_d;
  logic wr, rd, start_cmd;
  assign wr = psel & penable & pwrite;
  assign rd = psel & ~penable & ~pwrite;
  function automatic logic spd_ok(input logic [31:0] v);
    spd_ok = (v >= `AHEL_SPEED_MIN) && (v <= `AHEL_SPEED_MAX);
  endfunction
  function automatic logic [31:0] sabs(input logic [31:0] v);
    sabs = v[31] ? (~v + 32'h1) : v;
  endfunction
  logic [31:0] latch_q, latch_d, overrun_q, overrun_d, pos_q, pos_d;
  logic homed_q, homed_d;
  ahel_pkg::ahel_state_t st_q, st_d;
  always_comb
  begin
    ctrl_d = ctrl_q;
    origin_d = origin_q;
    cspd_d = cspd_q;
    fspd_d = fspd_q;
    back_d = back_q;
    lim_d = lim_q;
    start_cmd = 1'b0;
    if (wr)
    begin
      case (paddr)
        `AHEL_OFF_CTRL: ctrl_d = pwdata;
        // R10 origin clamp
        `AHEL_OFF_ORIGIN: origin_d = pwdata[31] ? 32'h0 :
          ((pwdata > lim_q) ? lim_q : pwdata);
        // R12 coarse range
        `AHEL_OFF_CSPEED: if (spd_ok(pwdata)) cspd_d = pwdata;
        // R14 fine range
        `AHEL_OFF_FSPEED: if (spd_ok(pwdata)) fspd_d = pwdata;
        // R15 back-off range
        `AHEL_OFF_BACKOFF:
          if (sabs(pwdata) <= `AHEL_BACKOFF_MAX) back_d = pwdata;
        `AHEL_OFF_LIMIT: lim_d = pwdata;
        `AHEL_OFF_CMD: start_cmd = pwdata[0];
        default: ;
      endcase
    end
    prdata_d = 32'h0;
    case (paddr)
      `AHEL_OFF_CTRL: prdata_d = ctrl_q;
      `AHEL_OFF_ORIGIN: prdata_d = origin_q;
      `AHEL_OFF_CSPEED: prdata_d = cspd_q;
      `AHEL_OFF_FSPEED: prdata_d = fspd_q;
      `AHEL_OFF_BACKOFF: prdata_d = back_q;
      `AHEL_OFF_LIMIT: prdata_d = lim_q;
      `AHEL_OFF_STATUS: prdata_d = {24'h0, homed_q, st_q};
      `AHEL_OFF_LATCH: prdata_d = latch_q;
      `AHEL_OFF_OVERRUN: prdata_d = overrun_q;
      `AHEL_OFF_POS: prdata_d = pos_q;
      default: prdata_d = 32'h0;
    endcase
    if (!rd)
      prdata_d = prdata;
  end
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      ctrl_q <= `AHEL_CTRL_RST;
      origin_q <= `AHEL_ORIGIN_RST;
      cspd_q <= `AHEL_CSPEED_RST;
      fspd_q <= `AHEL_FSPEED_RST;
      back_q <= `AHEL_BACKOFF_RST;
      lim_q <= `AHEL_LIMIT_RST;
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      ctrl_q <= ctrl_d;
      origin_q <= origin_d;
      cspd_q <= cspd_d;
      fspd_q <= fspd_d;
      back_q <= back_d;
      lim_q <= lim_d;
      prdata <= prdata_d;
      // no wait state: ready in the first access cycle
      pready <= psel & ~penable;
      pslverr <= 1'b0;
    end
  end

  // ----------------------------------------------------------
  // homing sequencer
  // ----------------------------------------------------------
  logic [7:0] pass_q, pass_d;
  logic move_run_d, dir_d, rstart_d, aux_d, allow_d;
  logic [31:0] spd_d, rdist_d;
  logic clr_rst, clr_es;
  assign clr_rst = ctrl_q[`AHEL_B_CLR_RST] & sys_reset_evt;
  assign clr_es = ctrl_q[`AHEL_B_CLR_ESTOP] & es_rise;
  always_comb
  begin
    st_d = st_q;
    pass_d = pass_q;
    latch_d = latch_q;
    overrun_d = overrun_q;
    pos_d = pos_q;
    homed_d = homed_q;
    move_run_d = 1'b0;
    dir_d = move_dir_neg;
    spd_d = move_speed;
    rstart_d = 1'b0;
    rdist_d = retract_dist;
    case (st_q)
      ahel_pkg::AHEL_IDLE:
        // R20 flow select
        if (start_cmd && ctrl_q[`AHEL_B_ENC_EN] && !es_st_q)
        begin
          st_d = ahel_pkg::AHEL_COARSE;
          homed_d = 1'b0;
          pass_d = ctrl_q[`AHEL_B_PASS+7:`AHEL_B_PASS];
        end
      ahel_pkg::AHEL_COARSE:
      begin
        // R11 coarse direction
        dir_d = ctrl_q[`AHEL_B_CDIR];
        spd_d = cspd_q;
        move_run_d = 1'b1;
        // R2 stop on switch
        if (sw_st_q)
        begin
          move_run_d = 1'b0;
          st_d = ahel_pkg::AHEL_CRETRACT;
        end
      end
      ahel_pkg::AHEL_CRETRACT:
      begin
        // R3 coarse retract
        dir_d = ~ctrl_q[`AHEL_B_CDIR];
        spd_d = cspd_q;
        move_run_d = sw_st_q;
        if (!sw_st_q)
          st_d = ahel_pkg::AHEL_FINE;
      end
      ahel_pkg::AHEL_FINE:
      begin
        // R13 fine direction
        dir_d = ctrl_q[`AHEL_B_FDIR];
        spd_d = fspd_q;
        move_run_d = 1'b1;
        // R4 index latch
        if (ix_rise)
        begin
          latch_d = encoder_count;
          move_run_d = 1'b0;
          st_d = ahel_pkg::AHEL_FSTOP;
        end
      end
      ahel_pkg::AHEL_FSTOP:
        if (drive_done)
        begin
          // R5 overrun
          overrun_d = encoder_count - latch_q;
          // R16 fine passes; R1 one pass when count is one
          if (pass_q > 8'h1)
          begin
            pass_d = pass_q - 8'h1;
            st_d = ahel_pkg::AHEL_FINE;
          end
          else
          begin
            // R6 actual retract
            rdist_d = back_q - (encoder_count - latch_q);
            rstart_d = 1'b1;
            st_d = ahel_pkg::AHEL_RETRACT;
          end
        end
      ahel_pkg::AHEL_RETRACT:
        if (drive_done && !retract_start)
        begin
          // R21 mark after retract
          homed_d = 1'b1;
          pos_d = origin_q;
          st_d = ahel_pkg::AHEL_DONE;
        end
      ahel_pkg::AHEL_DONE:
        st_d = ahel_pkg::AHEL_IDLE;
      default:
        st_d = ahel_pkg::AHEL_IDLE;
    endcase
    // R17 position correction after estop
    if (es_rise && ctrl_q[`AHEL_B_ENC_EN])
      pos_d = encoder_count;
    // R22 estop abort
    if (es_st_q && st_q != ahel_pkg::AHEL_IDLE)
    begin
      st_d = ahel_pkg::AHEL_IDLE;
      move_run_d = 1'b0;
      rstart_d = 1'b0;
      homed_d = 1'b0;
    end
    // R7 reset clear; R8 estop clear
    if (clr_rst || clr_es)
      homed_d = 1'b0;
    // R9 interlock
    allow_d = homed_d || !ctrl_q[`AHEL_B_REQ_HOME];
    // R19 aux functions wait for homing
    aux_d = homed_d;
  end
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      st_q <= ahel_pkg::AHEL_IDLE;
      pass_q <= 8'h0;
      latch_q <= 32'h0;
      overrun_q <= 32'h0;
      pos_q <= 32'h0;
      homed_q <= 1'b0;
      move_run <= 1'b0;
      move_dir_neg <= 1'b0;
      move_speed <= 32'h0;
      retract_start <= 1'b0;
      retract_dist <= 32'h0;
      motion_allowed <= 1'b0;
      aux_enable <= 1'b0;
    end
    else
    begin
      st_q <= st_d;
      pass_q <= pass_d;
      latch_q <= latch_d;
      overrun_q <= overrun_d;
      pos_q <= pos_d;
      homed_q <= homed_d;
      move_run <= move_run_d;
      move_dir_neg <= dir_d;
      move_speed <= spd_d;
      retract_start <= rstart_d;
      retract_dist <= rdist_d;
      motion_allowed <= allow_d;
      aux_enable <= aux_d;
    end
  end
  assign homed = homed_q;

  // ----------------------------------------------------------
  // assertions
  // ----------------------------------------------------------
  coarse_stop_a: assert property (@(posedge clk) disable iff (reset) // R2
    (st_q == ahel_pkg::AHEL_COARSE && sw_st_q && !es_st_q) |=> !move_run)
    else $error("coarse search did not stop on switch");
  fine_latch_a: assert property (@(posedge clk) disable iff (reset) // R4
    (st_q == ahel_pkg::AHEL_FINE && ix_rise && !es_st_q)
    |=> latch_q == $past(encoder_count))
    else $error("index count not latched");
  homed_after_a: assert property (@(posedge clk) disable iff (reset) // R21
    $rose(homed_q) |-> $past(st_q) == ahel_pkg::AHEL_RETRACT)
    else $error("homed set outside retract");
  estop_abort_a: assert property (@(posedge clk) disable iff (reset) // R22
    (es_st_q && st_q != ahel_pkg::AHEL_IDLE)
    |=> st_q == ahel_pkg::AHEL_IDLE && !homed_q)
    else $error("estop did not abort homing");
  interlock_a: assert property (@(posedge clk) disable iff (reset) // R9
    ctrl_q[`AHEL_B_REQ_HOME] |=> motion_allowed == homed_q)
    else $error("motion permission does not follow homed mark");
  retract_calc_a: assert property (@(posedge clk) disable iff (reset) // R6
    retract_start |-> retract_dist == $past(back_q) - overrun_q)
    else $error("retract distance wrong");
endmodule

/* ahel_axis_model.sv */
// behavioural axis drive with home switch belts and encoder index
`timescale 1ns/1ps
module ahel_axis_model #(
  parameter int COAST = 3
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic move_run,
  input wire logic move_dir_neg,
  input wire logic retract_start,
  input wire logic [31:0] retract_dist,
  output logic home_switch,
  output logic encoder_index,
  output logic drive_done,
  output logic [31:0] encoder_count
);
  int pos;
  int coast;
  int rem;
  logic neg;
  always @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      pos <= 0;
      coast <= 0;
      rem <= 0;
      neg <= 0;
    end
    else if (retract_start)
      rem <= $signed(retract_dist);
    else if (move_run)
    begin
      neg <= move_dir_neg;
      coast <= COAST;
      pos <= move_dir_neg ? pos - 1 : pos + 1;
    end
    // inertia: the axis keeps going a few steps after the stop
    else if (coast > 0)
    begin
      coast <= coast - 1;
      pos <= neg ? pos - 1 : pos + 1;
    end
    else if (rem != 0)
    begin
      rem <= rem > 0 ? rem - 1 : rem + 1;
      pos <= rem > 0 ? pos + 1 : pos - 1;
    end
  end
  assign home_switch = (pos >= 80 && pos <= 140) || (pos <= -80 && pos >= -140);
  // index zone four counts wide so the pin synchroniser can see it
  assign encoder_index = (pos & 15) < 4;
  assign drive_done = !move_run && coast == 0 && rem == 0;
  assign encoder_count = pos;
endmodule

/* testbench.sv */
// self-checking bench for the axis homing sequencer
`timescale 1ns/1ps
`include "ahel_cfg.svh"
module testbench;
  logic clk = 0;
  logic reset = 1;
  logic psel = 0;
  logic penable = 0;
  logic pwrite = 0;
  logic estop = 0;
  logic sys_reset_evt = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0;
  logic [31:0] prdata, rd, rest, rdist, cs, fs, bo, lat;
  logic pready, pslverr, move_run, move_dir_neg, retract_start;
  logic motion_allowed, homed, aux_enable, home_switch, encoder_index;
  logic drive_done, prun, pdir;
  logic [31:0] move_speed, retract_dist, encoder_count, pspd;
  int bad_count = 0;
  int total_checks = 0;
  int cycles = 0;
  int npulse = 0;
  logic q_dir[$];
  logic [31:0] q_spd[$];
  logic [11:0] offs[7] = '{`AHEL_OFF_CTRL, `AHEL_OFF_ORIGIN, `AHEL_OFF_CSPEED,
    `AHEL_OFF_FSPEED, `AHEL_OFF_BACKOFF, `AHEL_OFF_LIMIT, 12'h0fc};
  logic [31:0] rsts[7] = '{`AHEL_CTRL_RST, `AHEL_ORIGIN_RST, `AHEL_CSPEED_RST,
    `AHEL_FSPEED_RST, `AHEL_BACKOFF_RST, `AHEL_LIMIT_RST, 32'h0};
  ahel_homing uut (.clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .home_switch, .encoder_index, .estop,
    .sys_reset_evt, .drive_done, .encoder_count, .move_run, .move_dir_neg,
    .move_speed, .retract_start, .retract_dist, .motion_allowed, .homed,
    .aux_enable);
  ahel_axis_model mdl (.clk, .reset, .move_run, .move_dir_neg, .retract_start,
    .retract_dist, .home_switch, .encoder_index, .drive_done, .encoder_count);
  always #10 clk = ~clk;
  task conclude;
    if (bad_count == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e)
    begin
      $display("unexpected %s expected %h seen %h", n, e, g);
      bad_count++;
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    @(posedge clk);
    while (pready !== 1'b1)
      @(posedge clk);
    rd = prdata;
    chk("pslverr", 0, pslverr);
    psel <= 0;
    penable <= 0;
    @(posedge clk);
  endtask
  // estop is a pin and must outlast the synchroniser; reset event is one clock
  task evt(input logic es, input int n);
    if (es)
      estop <= 1;
    else
      sys_reset_evt <= 1;
    repeat (es ? 4 : 1) @(posedge clk);
    estop <= 0;
    sys_reset_evt <= 0;
    repeat (n) @(posedge clk);
  endtask
  // ----------------------------------------
  // monitor: move segments, retract pulse, hang limit
  // ----------------------------------------
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      bad_count++;
      conclude();
    end
    if (move_run && (!prun || move_dir_neg != pdir || move_speed != pspd))
    begin
      q_dir.push_back(move_dir_neg);
      q_spd.push_back(move_speed);
    end
    if (retract_start)
    begin
      npulse++;
      rest = encoder_count;
      rdist = retract_dist;
      chk("homed_at_retract", 0, homed); // mark late
    end
    prun <= move_run;
    pdir <= move_dir_neg;
    pspd <= move_speed;
  end
  task home(input logic cd, input logic fd, input logic [31:0] clr);
    int n;
    logic [31:0] b;
    q_dir.delete();
    q_spd.delete();
    npulse = 0;
    n = 0;
    // back off against the fine search so the axis rests clear of the belt
    b = fd ? bo : -bo;
    apb(1, `AHEL_OFF_BACKOFF, b); // back-off
    apb(1, `AHEL_OFF_CTRL, 32'h10a | clr | (32'(cd) << 4) | (32'(fd) << 5));
    apb(1, `AHEL_OFF_CMD, 32'h1);
    while (homed !== 1'b1 && n < 3000)
    begin
      @(posedge clk);
      n++;
    end
    chk("homed", 1, homed); // mark set
    chk("retracts", 1, npulse); // one pass
    chk("segments", 1, q_dir.size() inside {[2:3]}); // one pass
    chk("coarse_dir", cd, q_dir[0]); // direction
    chk("coarse_speed", cs, q_spd[0]); // speed used
    chk("retreat_dir", !cd, q_dir[1]); // retract first
    chk("fine_dir", fd, q_dir[$]); // direction
    chk("fine_speed", fs, q_spd[$]); // speed used
    apb(0, `AHEL_OFF_LATCH, 0);
    lat = rd;
    apb(0, `AHEL_OFF_OVERRUN, 0);
    chk("overrun", rest - lat, rd); // overrun
    chk("retract_dist", b - rd, rdist); // actual retract
    chk("allowed", 1, motion_allowed); // interlock
    chk("aux", 1, aux_enable); // functions on
  endtask
  initial
  begin
    void'($urandom(32'h16b9));
    repeat (10) @(posedge clk);
    reset <= 0;
    @(posedge clk);
    chk("allowed_rst", 0, motion_allowed); // interlock
    chk("aux_rst", 0, aux_enable); // functions off
    for (int i = 0; i < 7; i++)
    begin
      apb(0, offs[i], 0);
      chk("reset_value", rsts[i], rd); // defaults
    end
    apb(1, 12'h0fc, 32'hffffffff);
    apb(0, 12'h0fc, 0);
    chk("unmapped", 0, rd);
    apb(1, `AHEL_OFF_CSPEED, 0);
    apb(0, `AHEL_OFF_CSPEED, 0);
    chk("cspeed_low", `AHEL_CSPEED_RST, rd); // range
    apb(1, `AHEL_OFF_FSPEED, `AHEL_SPEED_MAX + 1);
    apb(0, `AHEL_OFF_FSPEED, 0);
    chk("fspeed_high", `AHEL_FSPEED_RST, rd); // range
    apb(1, `AHEL_OFF_BACKOFF, `AHEL_BACKOFF_MAX + 1);
    apb(0, `AHEL_OFF_BACKOFF, 0);
    chk("backoff_high", 0, rd); // range
    apb(1, `AHEL_OFF_BACKOFF, -`AHEL_BACKOFF_MAX);
    apb(0, `AHEL_OFF_BACKOFF, 0);
    chk("backoff_min", -`AHEL_BACKOFF_MAX, rd); // range
    apb(1, `AHEL_OFF_LIMIT, 32'h1000);
    apb(1, `AHEL_OFF_ORIGIN, 32'h1001);
    apb(0, `AHEL_OFF_ORIGIN, 0);
    chk("origin_clamp", 32'h1000, rd); // clamp
    cs = $urandom % `AHEL_SPEED_MAX + 1;
    fs = $urandom % `AHEL_SPEED_MAX + 1;
    bo = 32'h14 + $urandom % 32'h15;
    apb(1, `AHEL_OFF_CSPEED, cs);
    apb(1, `AHEL_OFF_FSPEED, fs);
    apb(1, `AHEL_OFF_BACKOFF, bo);
    apb(0, `AHEL_OFF_CSPEED, 0);
    chk("cspeed", cs, rd); // accepted
    apb(1, `AHEL_OFF_CTRL, 32'h102);
    apb(1, `AHEL_OFF_CMD, 32'h1);
    repeat (20) @(posedge clk);
    chk("no_flow", 0, move_run); // enable
    home(0, 0, 32'h0);
    evt(0, 3);
    chk("keep_on_reset", 1, homed); // flag clear
    evt(1, 8);
    chk("keep_on_estop", 1, homed); // flag clear
    apb(0, `AHEL_OFF_POS, 0);
    chk("pos_follow", encoder_count, rd); // correction
    // recommended clearing on reset, none on estop
    apb(1, `AHEL_OFF_CTRL, 32'h10b);
    evt(0, 3);
    chk("clear_on_reset", 0, homed); // flag set
    home(1, 1, 32'h5);
    evt(1, 8);
    chk("clear_on_estop", 0, homed); // flag set
    apb(1, `AHEL_OFF_CMD, 32'h1);
    repeat (5) @(posedge clk);
    chk("abort_moving", 1, move_run); // abort
    estop <= 1;
    repeat (8) @(posedge clk);
    chk("abort_stop", 0, move_run); // abort
    chk("abort_mark", 0, homed); // abort
    apb(0, `AHEL_OFF_STATUS, 0);
    chk("abort_state", ahel_pkg::AHEL_IDLE, rd[6:0]); // abort
    estop <= 0;
    apb(1, `AHEL_OFF_CTRL, 32'h108);
    repeat (2) @(posedge clk);
    chk("no_interlock", 1, motion_allowed); // skipped
    conclude();
  end
endmodule
